// [rtl/base10k_digit.sv]
/*
  one digit group of the base-10000 counter: quotient and remainder.
  assumes truncating signed division so digit and value share sign.
*/
`timescale 1ns/1ps
module base10k_digit
  import codec_pkg::*;
(
  input  wire logic signed [63:0] v,
  output logic signed [63:0]      q,
  output logic signed [15:0]      r
);
  logic signed [63:0] rem;

  // digit split, remainder within +-9999
  always_comb
  begin
    q   = v / BASE;           // R9
    rem = v - q * BASE;
    r   = rem[15:0];          // R8
  end
endmodule

// [rtl/codec_pkg.sv]
/*
  constants, formats and carriers of the register value format codec.
  assumes a 32-bit apb slave with 16-bit register images in five lanes.
*/
// Notes on behaviour
// [R1] multi-word integers: most significant word first
// [R2] words combine unsigned; only top bit signs
// [R3] signed use two's complement, unsigned all positive
// [R4] fixed point holds value times scale factor
// [R5] float sign bit on top, 1 negative
// [R6] 8-bit exponent biased by 127
// [R7] 23-bit fraction, value one plus fraction
// [R8] counter digits limited to -9999..9999
// [R9] counter value sums digits times 10000^index
// [R10] plain date three words, millis adds fourth
// [R11] word1 day, month, quality flag bit 15
// [R12] quality flag set unsynced or after reset
// [R13] word2 hours, year code; word3 seconds, minutes
// [R14] fourth date word milliseconds 0..999
// [R15] iec word1 year offset from 2000
// [R16] iec day/month, minutes/hours, milliseconds words
// [R17] optional iec quality word bits 12..14
// [R18] strobe in, full image next cycle
// [R19] reserved date bits written zero, ignored
package codec_pkg;
  localparam int LANES = 5;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_NLO  = 8'h08;
  localparam logic [7:0] OFF_NHI  = 8'h0C;
  localparam logic [7:0] OFF_IMG  = 8'h10;
  localparam int CTRL_ENC = 0;
  localparam int CTRL_DEC = 1;
  localparam int CTRL_FMT = 8;
  localparam int CTRL_SCL = 12;
  localparam int STAT_DONE = 0;
  localparam int STAT_ERR  = 1;
  localparam int STAT_SYNC = 2;
  localparam int STAT_SET  = 3;
  localparam logic signed [63:0] BASE = 64'sd10000;
  localparam logic signed [15:0] DIG_MAX = 16'sd9999;
  localparam logic [11:0] CAL_BASE = 12'd1900;
  localparam logic [11:0] IEC_BASE = 12'd2000;
  localparam logic [7:0]  CODE_MIN = 8'h50;
  localparam logic [7:0]  CODE_MAX = 8'hC7;
  localparam logic [15:0] MS_MAX = 16'h03E7;
  localparam logic [15:0] IEC_MS_MAX = 16'hEA5F;
  localparam logic [15:0] MS_PER_S = 16'd1000;
  localparam logic [7:0]  BIAS = 8'd127;
  localparam logic [7:0]  EXP_MAX = 8'hFF;
  localparam int QUAL_BIT = 15;
  localparam int IEC_EXT  = 12;
  localparam int IEC_SYNC = 13;
  localparam int IEC_SET  = 14;
  localparam logic signed [15:0] SCALE1 = 16'sd1;
  localparam logic signed [15:0] SCALE2 = 16'sd100;
  localparam logic signed [15:0] SCALE3 = 16'sd1000;
  typedef enum logic [3:0] {
    signed_single_word, unsigned_single_word, signed_double_word,
    unsigned_double_word, signed_quad_word, unsigned_quad_word,
    scaled_fixed_point, single_precision_real, base_ten_thousand_counter,
    calendar_date, calendar_date_with_millis, iec_calendar_stamp
  } fmt_e;
  typedef logic [LANES-1:0][15:0] img_t;
  typedef struct packed {
    logic [9:0]  pad;
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
    logic [15:0] millis;
  } date_s;
endpackage

// [rtl/float_unpack.sv]
/*
  splits a single precision word into fields and a truncated integer.
  assumes pure combinational use inside the codec.
*/
`timescale 1ns/1ps
module float_unpack
  import codec_pkg::*;
(
  input  wire logic [31:0]        f,
  output logic signed [31:0]      intVal,
  output logic                    special
);
  logic              sign;   // top bit
  logic [7:0]        expo;   // stored exponent
  logic signed [9:0] trueE;  // unbiased exponent
  logic [63:0]       shifted;
  logic [31:0]       mag;

  // field split and integer truncation toward zero
  always_comb
  begin
    sign    = f[31];                                      // R5
    expo    = f[30:23];
    trueE   = $signed({2'b00, expo}) - $signed({2'b00, BIAS}); // R6
    special = (expo == 8'h00) || (expo == EXP_MAX);
    shifted = 64'h0;
    mag     = 32'h0;
    if (!special && trueE >= 0 && trueE <= 10'sd30)
    begin
      shifted = {40'h0, 1'b1, f[22:0]} << trueE[4:0];     // R7
      mag     = shifted[54:23];
    end
    else if (!special && trueE > 10'sd30)
      mag = 32'h7FFFFFFF;                                  // saturate
    intVal = sign ? -$signed(mag) : $signed(mag);
  end
endmodule

// [rtl/value_codec.sv]
/*
  apb slave packing native values into 16-bit register images and back.
  assumes apb from a 250 MHz clock domain and an async time-sync pin.
*/
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module value_codec
  import codec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timeSynced
);
  fmt_e        fmt, next_fmt;          // selected format
  logic [1:0]  scale, next_scale;      // fixed point scale select
  logic [63:0] native, next_native;    // native value
  img_t        img, next_img;          // register image lanes
  logic        done, next_done;        // conversion finished
  logic        err, next_err;          // range violation, float special or illegal format
  logic [1:0]  go, next_go;            // encode/decode strobes
  logic        sync1, sync2;           // pin synchroniser
  logic        dateSet, next_dateSet;  // time set since reset
  img_t        encImg;
  logic        encErr;
  logic [63:0] decNative;
  logic        decErr;
  logic        access;
  logic signed [31:0] fltInt;
  logic               fltSpecial;
  logic signed [63:0] chainV [0:LANES-1];
  logic signed [63:0] chainQ [0:LANES-1];
  logic signed [15:0] digit  [0:LANES-1];

  // lane hit for image addresses
  function automatic logic laneHit(input logic [7:0] a);
    laneHit = (a >= OFF_IMG) && (a < OFF_IMG + 8'(4 * LANES)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] laneIdx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFF_IMG;
    laneIdx = d[4:2];
  endfunction

  // integer to single precision, truncating fraction
  function automatic logic [31:0] toFloat(input logic signed [31:0] v);
    logic [31:0] abs;
    logic [4:0]  pos;
    logic [31:0] norm;
    abs = v[31] ? 32'(-v) : 32'(v);
    pos = 5'd0;
    for (int i = 0; i < 32; i++)
      if (abs[i])
        pos = 5'(i);
    norm = abs << (5'd31 - pos);
    if (abs == 32'h0)
      toFloat = 32'h0;
    else
      toFloat = {v[31], 8'(BIAS + 8'(pos)), norm[30:8]}; // R5 R6 R7
  endfunction

  float_unpack uFloat (
    .f       (native[31:0]),
    .intVal  (),
    .special ()
  );

  float_unpack uFloatDec (
    .f       ({img[0], img[1]}),
    .intVal  (fltInt),
    .special (fltSpecial)
  );

  // digit chain for the counter, lane 0 least significant
  assign chainV[0] = $signed(native);
  generate
    for (genvar g = 0; g < LANES; g++)
    begin : gDigit
      base10k_digit uDig (
        .v (chainV[g]),
        .q (chainQ[g]),
        .r (digit[g])
      );
      if (g < LANES - 1)
      begin : gLink
        assign chainV[g+1] = chainQ[g];
      end
    end
  endgenerate

  // encoder: native value to register image
  always_comb
  begin
    date_s d;
    logic signed [47:0] prod;
    logic [31:0] flt;
    logic [11:0] yOff;
    logic [15:0] ms;
    d      = date_s'(native);
    prod   = 48'sh0;
    flt    = 32'h0;
    yOff   = 12'h0;
    ms     = 16'h0;
    encImg = '0;
    encErr = 1'b0;
    unique case (fmt)
      signed_single_word:
      begin
        encImg[0] = native[15:0];
        encErr    = !(&native[63:15] || !(|native[63:15]));
      end
      unsigned_single_word:
      begin
        encImg[0] = native[15:0];
        encErr    = |native[63:16];
      end
      signed_double_word, unsigned_double_word:
      begin
        encImg[0] = native[31:16];                          // R1
        encImg[1] = native[15:0];
        if (fmt == signed_double_word)
          encErr = !(&native[63:31] || !(|native[63:31]));  // R3
        else
          encErr = |native[63:32];
      end
      signed_quad_word, unsigned_quad_word:
      begin
        for (int i = 0; i < 4; i++)
          encImg[i] = native[16*(3-i) +: 16];               // R1
      end
      scaled_fixed_point:
      begin
        prod = $signed(native[31:0]) * (scale == 2'd1 ? SCALE2 :
               scale == 2'd2 ? SCALE3 : SCALE1);            // R4
        encImg[0] = prod[15:0];
        encErr    = !(&prod[47:15] || !(|prod[47:15]));
      end
      single_precision_real:
      begin
        flt       = toFloat($signed(native[31:0]));
        encImg[0] = flt[31:16];
        encImg[1] = flt[15:0];
      end
      base_ten_thousand_counter:
      begin
        for (int i = 0; i < LANES; i++)
          encImg[i] = digit[i];                             // R9
        encErr = chainQ[LANES-1] != 64'sh0;                 // R8
      end
      calendar_date, calendar_date_with_millis:
      begin
        yOff      = d.year - CAL_BASE;
        encImg[0] = {!(sync2 && dateSet), 3'b000, d.month, 3'b000, d.day}; // R11 R12
        encImg[1] = {yOff[7:0], 3'b000, d.hour};            // R13
        encImg[2] = {2'b00, d.minute, 2'b00, d.second};     // R13
        if (fmt == calendar_date_with_millis)
          encImg[3] = d.millis;                             // R10 R14
        encErr = yOff[7:0] < CODE_MIN || yOff > 12'(CODE_MAX) ||
                 (fmt == calendar_date_with_millis && d.millis > MS_MAX);
      end
      iec_calendar_stamp:
      begin
        yOff      = d.year - IEC_BASE;
        ms        = 16'(d.second) * MS_PER_S + d.millis;
        encImg[0] = {9'h000, yOff[6:0]};                    // R15 R19
        encImg[1] = {4'h0, d.month, 3'b000, d.day};         // R16 R19
        encImg[2] = {3'b000, d.hour, 2'b00, d.minute};      // R16
        encImg[3] = ms;                                     // R16
        encImg[4][IEC_EXT]  = sync2;                        // R17
        encImg[4][IEC_SYNC] = sync2;
        encImg[4][IEC_SET]  = dateSet;
        encErr = yOff > 12'h07F || ms > IEC_MS_MAX;
      end
      default:
        encErr = 1'b1;
    endcase
  end

  // decoder: register image to native value
  always_comb
  begin
    date_s d;
    logic signed [63:0] acc;
    logic signed [63:0] wt;
    d         = '0;
    acc       = 64'sh0;
    wt        = 64'sh1;
    decNative = 64'h0;
    decErr    = 1'b0;
    unique case (fmt)
      signed_single_word, scaled_fixed_point:
        decNative = {{48{img[0][15]}}, img[0]};             // R4
      unsigned_single_word:
        decNative = {48'h0, img[0]};
      signed_double_word:
        decNative = {{32{img[0][15]}}, img[0], img[1]};     // R2 R3
      unsigned_double_word:
        decNative = {32'h0, img[0], img[1]};                // R2
      signed_quad_word, unsigned_quad_word:
        decNative = {img[0], img[1], img[2], img[3]};       // R2
      single_precision_real:
      begin
        decNative = {{32{fltInt[31]}}, fltInt};             // R7
        decErr    = fltSpecial && (img[0][14:0] != 15'h0 || img[1] != 16'h0);
      end
      base_ten_thousand_counter:
      begin
        for (int i = 0; i < LANES; i++)
        begin
          acc = acc + $signed(img[i]) * wt;                 // R9
          wt  = wt * BASE;
          if ($signed(img[i]) > DIG_MAX || $signed(img[i]) < -DIG_MAX)
            decErr = 1'b1;                                  // R8
        end
        decNative = acc;
      end
      calendar_date, calendar_date_with_millis:
      begin
        d.day    = img[0][4:0];                             // R11 R19
        d.month  = img[0][11:8];
        d.hour   = img[1][4:0];                             // R13
        d.year   = CAL_BASE + 12'(img[1][15:8]);
        d.second = img[2][5:0];
        d.minute = img[2][13:8];
        if (fmt == calendar_date_with_millis)
          d.millis = img[3];                                // R14
        decNative = d;
        decErr    = img[1][15:8] < CODE_MIN || img[1][15:8] > CODE_MAX;
      end
      iec_calendar_stamp:
      begin
        d.year    = IEC_BASE + 12'(img[0][6:0]);            // R15 R19
        d.day     = img[1][4:0];                            // R16
        d.month   = img[1][11:8];
        d.minute  = img[2][5:0];
        d.hour    = img[2][12:8];
        d.second  = 6'(img[3] / MS_PER_S);
        d.millis  = img[3] % MS_PER_S;
        decNative = d;
        decErr    = img[3] > IEC_MS_MAX;
      end
      default:
        decErr = 1'b1;
    endcase
  end

  assign access  = psel && penable && ce;
  assign pready  = ce;
  assign pslverr = psel && penable && !(paddr == OFF_CTRL || paddr == OFF_STAT ||
                   paddr == OFF_NLO || paddr == OFF_NHI || laneHit(paddr));

  // register writes and conversion results
  always_comb
  begin
    next_fmt     = fmt;
    next_scale   = scale;
    next_native  = native;
    next_img     = img;
    next_done    = done;
    next_err     = err;
    next_go      = 2'b00;
    next_dateSet = dateSet || sync2;                        // R12
    if (access && pwrite)
    begin
      if (paddr == OFF_CTRL)
      begin
        next_fmt   = fmt_e'(pwdata[CTRL_FMT +: 4]);
        next_scale = pwdata[CTRL_SCL +: 2];
        next_go    = {pwdata[CTRL_DEC], pwdata[CTRL_ENC]};
        next_done  = 1'b0;
      end
      else if (paddr == OFF_NLO)
        next_native[31:0] = pwdata;
      else if (paddr == OFF_NHI)
        next_native[63:32] = pwdata;
      else if (laneHit(paddr))
        next_img[laneIdx(paddr)] = pwdata[15:0];
    end
    // result wins over a same-cycle bus write
    if (go[CTRL_ENC])
    begin
      next_img  = encImg;                                   // R18
      next_err  = encErr;
      next_done = 1'b1;
    end
    else if (go[CTRL_DEC])
    begin
      next_native = decNative;                              // R18
      next_err    = decErr;
      next_done   = 1'b1;
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt     <= signed_single_word;
      scale   <= 2'b00;
      native  <= 64'h0;
      img     <= '0;
      done    <= 1'b0;
      err     <= 1'b0;
      go      <= 2'b00;
      sync1   <= 1'b0;
      sync2   <= 1'b0;
      dateSet <= 1'b0;
    end
    else if (ce)
    begin
      fmt     <= next_fmt;
      scale   <= next_scale;
      native  <= next_native;
      img     <= next_img;
      done    <= next_done;
      err     <= next_err;
      go      <= next_go;
      sync1   <= timeSynced;
      sync2   <= sync1;
      dateSet <= next_dateSet;
    end
  end

  // read mux
  always_comb
  begin
    prdata = 32'h0;
    if (psel && !pwrite)
    begin
      if (paddr == OFF_CTRL)
        prdata = {18'h0, scale, fmt, 8'h00};
      else if (paddr == OFF_STAT)
        prdata = {28'h0, dateSet, sync2, err, done};
      else if (paddr == OFF_NLO)
        prdata = native[31:0];
      else if (paddr == OFF_NHI)
        prdata = native[63:32];
      else if (laneHit(paddr))
        prdata = {16'h0, img[laneIdx(paddr)]};
    end
  end

  msb_first_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    ce && go[CTRL_ENC] && (fmt == signed_double_word || fmt == unsigned_double_word) |=>
    img[0] == $past(native[31:16]) && img[1] == $past(native[15:0]))
    else $error("double word not msb first");
  words_unsigned_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    ce && go[CTRL_DEC] && fmt == unsigned_quad_word |=>
    native == {$past(img[0]), $past(img[1]), $past(img[2]), $past(img[3])})
    else $error("quad word combine wrong");
  sign_extend_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    ce && go[CTRL_DEC] && fmt == signed_double_word |=>
    native[63:32] == {32{$past(img[0][15])}})
    else $error("signed double not extended");
  float_sign_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    ce && go[CTRL_ENC] && fmt == single_precision_real && native[31:0] != 32'h0 |=>
    img[0][15] == $past(native[31]))
    else $error("float sign wrong");
  float_small_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    ce && go[CTRL_DEC] && fmt == single_precision_real && img[0][14:7] < BIAS |=>
    native == 64'h0)
    else $error("fraction below one not zero");
  digit_range_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    ce && go[CTRL_ENC] && fmt == base_ten_thousand_counter |=>
    $signed(img[0]) <= DIG_MAX && $signed(img[0]) >= -DIG_MAX)
    else $error("counter digit out of range");
  date_quality_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    ce && go[CTRL_ENC] && fmt == calendar_date && !dateSet |=> img[0][QUAL_BIT])
    else $error("quality flag clear before time set");
  iec_reserved_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
    ce && go[CTRL_ENC] && fmt == iec_calendar_stamp |=>
    img[0][15:7] == 9'h0 && img[1][7:5] == 3'h0 && img[2][15:13] == 3'h0)
    else $error("iec reserved bits set");
  result_next_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
    ce && access && pwrite && paddr == OFF_CTRL && pwdata[CTRL_ENC] |=>
    ##1 done) else $error("no result two cycles after start");
endmodule

// [verif/apb_host.sv]
/*
  apb master standing in for the host that drives the codec registers.
  assumes one clock, pready sampled at rising edges, 32-bit data.
*/
`timescale 1ns/1ps
module apb_host
  import codec_pkg::*;
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // one transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait states allowed: hold all until pready
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data no longer shows last value
    pwdata <= ~d;
    paddr <= ~a;
  endtask
endmodule

// [verif/tb.sv]
/*
  self-checking bench of the value codec through its apb registers.
  assumes apb_host as master and the codec_pkg offsets and fmt codes.
*/
`timescale 1ns/1ps
module tb
  import codec_pkg::*;
;
  logic        clk;         // 250 MHz
  logic        rstN;        // async reset
  logic        ce;          // clock enable
  logic        timeSynced;  // sync pin
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          badCount;    // mismatches
  int          compares;    // comparisons
  int          cyc;         // timeout counter
  logic [31:0] rdat;        // last read data
  logic        rerr;        // last slave error
  logic [31:0] stat;        // status after run

  value_codec u_value_codec (.clk(clk), .rst_n(rstN), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timeSynced(timeSynced));
  apb_host u_apb_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // clock generator
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      badCount++;
      close_out();
    end
  end

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      badCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_apb_host.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rd(input logic [7:0] a);
    u_apb_host.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
  endtask

  // native value over the two words
  task automatic nat(input logic [63:0] v);
    wr(OFF_NLO, v[31:0]);
    wr(OFF_NHI, v[63:32]);
  endtask

  // load all five lanes, low half of each word
  task automatic lanes(input logic [4:0][15:0] v);
    for (int i = 0; i < LANES; i++)
      wr(OFF_IMG + 8'(4 * i), {16'h0000, v[i]});
  endtask

  // start a conversion and poll done
  task automatic run(input logic [3:0] f, input logic [1:0] s, input logic [1:0] op);
    wr(OFF_CTRL, {18'h0, s, f, 6'h00, op});
    stat = 32'h0000_0000;
    for (int i = 0; i < 10 && stat[STAT_DONE] !== 1'b1; i++)
    begin
      rd(OFF_STAT);
      stat = rdat;
    end
    check(stat[STAT_DONE], 1'b1);
  endtask

  task automatic lane(input int i, input logic [15:0] exp);
    rd(OFF_IMG + 8'(4 * i));
    check(rdat[15:0], exp);
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    badCount = 0;
    compares = 0;
    cyc = 0;
    rstN = 1'b0;
    ce = 1'b1;
    timeSynced = 1'b0;
    repeat (12) @(posedge clk);
    rstN <= 1'b1;
    rd(OFF_STAT);
    check(rdat, 32'h0000_0000);
    lane(0, 16'h0000);
    $display("reset test done");
    // integers, msb word first
    nat(64'hFFFF_FFFF_FFF2_A96E);
    run(4'h2, 2'h0, 2'h1);
    lane(0, 16'hFFF2);
    lane(1, 16'hA96E);
    lanes({16'h0000, 16'h9692, 16'h0017, 16'h0000, 16'h0000});
    run(4'h5, 2'h0, 2'h2);
    rd(OFF_NLO);
    check(rdat, 32'h0017_9692);
    rd(OFF_NHI);
    check(rdat, 32'h0000_0000);
    lanes({16'h0000, 16'h0000, 16'h0000, 16'hA96E, 16'hFFF2});
    run(4'h2, 2'h0, 2'h2);
    rd(OFF_NHI);
    check(rdat, 32'hFFFF_FFFF);
    $display("integer test done");
    // fixed point over the scales
    nat(64'd123);
    run(4'h6, 2'h1, 2'h1);
    lane(0, 16'h300C);
    nat(64'hFFFF_FFFF_FFFF_FFFB);
    run(4'h6, 2'h2, 2'h1);
    lane(0, 16'hEC78);
    nat(64'h0000_7FFF);
    run(4'h6, 2'h0, 2'h1);
    lane(0, 16'h7FFF);
    nat(64'd400);
    run(4'h6, 2'h1, 2'h1);
    check(stat[STAT_ERR], 1'b1);
    $display("fixed test done");
    // float both ways
    nat(64'hFFFF_FFFF_FFFF_FFFE);
    run(4'h7, 2'h0, 2'h1);
    lane(0, 16'hC000);
    lane(1, 16'h0000);
    lanes({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hBFC0});
    run(4'h7, 2'h0, 2'h2);
    rd(OFF_NLO);
    check(rdat, 32'hFFFF_FFFF);
    // magnitude below one truncates to zero
    lanes({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hBF00});
    run(4'h7, 2'h0, 2'h2);
    rd(OFF_NLO);
    check(rdat, 32'h0000_0000);
    rd(OFF_NHI);
    check(rdat, 32'h0000_0000);
    $display("float test done");
    // counter decode and digit limit
    lanes({16'h0000, 16'h0000, 16'h0059, 16'h11D7, 16'h007B});
    run(4'h8, 2'h0, 2'h2);
    rd(OFF_NLO);
    check(rdat, 32'h1534_17EB);
    rd(OFF_NHI);
    check(rdat, 32'h0000_0002);
    lanes({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h2710});
    run(4'h8, 2'h0, 2'h2);
    check(stat[STAT_ERR], 1'b1);
    // counter encode, digits low lane first
    nat(64'h0000_0002_1534_17EB);
    run(4'h8, 2'h0, 2'h1);
    check(stat[STAT_ERR], 1'b0);
    lane(0, 16'h007B);
    lane(1, 16'h11D7);
    lane(2, 16'h0059);
    lane(3, 16'h0000);
    $display("counter test done");
    // calendar date, unsynced then synced
    nat({10'h000, 12'h7DC, 4'h5, 5'h13, 5'h0A, 6'h22, 6'h2E, 16'h0358});
    run(4'hA, 2'h0, 2'h1);
    lane(0, 16'h8513);
    lane(1, 16'h700A);
    lane(2, 16'h222E);
    lane(3, 16'h0358);
    run(4'h9, 2'h0, 2'h1);
    lane(3, 16'h0000);
    timeSynced <= 1'b1;
    repeat (4) @(posedge clk);
    run(4'hA, 2'h0, 2'h1);
    lane(0, 16'h0513);
    check(stat[3:2], 2'b11);
    // date decode ignores the quality flag
    lanes({16'h0000, 16'h0358, 16'h222E, 16'h700A, 16'h8513});
    run(4'hA, 2'h0, 2'h2);
    rd(OFF_NLO);
    check(rdat, 32'hA8AE_0358);
    rd(OFF_NHI);
    check(rdat, 32'h001F_7166);
    $display("date test done");
    // iec stamp with quality word
    nat({10'h000, 12'h7DD, 4'h5, 5'h13, 5'h0A, 6'h22, 6'h2E, 16'h0358});
    run(4'hB, 2'h0, 2'h1);
    lane(0, 16'h000D);
    lane(1, 16'h0513);
    lane(2, 16'h0A22);
    lane(3, 16'hB708);
    lane(4, 16'h7000);
    // iec decode with reserved bits set in the year word
    lanes({16'h7000, 16'hB708, 16'h0A22, 16'h0513, 16'hFF8D});
    run(4'hB, 2'h0, 2'h2);
    rd(OFF_NLO);
    check(rdat, 32'hA8AE_0358);
    rd(OFF_NHI);
    check(rdat, 32'h001F_7566);
    $display("iec test done");
    // unmapped place and illegal format
    // clock enable low stretches the access phase
    ce <= 1'b0;
    fork
      wr(OFF_NLO, 32'h0000_00AA);
      begin
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    rd(OFF_NLO);
    check(rdat, 32'h0000_00AA);
    rd(8'h40);
    check(rerr, 1'b1);
    check(rdat, 32'h0000_0000);
    wr(8'h44, 32'h1234_5678);
    check(rerr, 1'b1);
    run(4'hC, 2'h0, 2'h1);
    check(stat[STAT_ERR], 1'b1);
    lane(0, 16'h0000);
    $display("error test done");
    close_out();
  end
endmodule
